/* File: rtl/hrl_pkg.sv */
// Package: constants, enums and carrier structs for the hub reset and link power block
package hrl_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_MHZ         = 10;
  localparam int CNT_W           = 16;
  localparam int POR_HOLD_US     = 100;
  localparam int POR_HOLD_CYC    = POR_HOLD_US * CLK_MHZ;
  localparam int SLEEP_ENTRY_US  = 10;
  localparam int SLEEP_EXIT_US   = 50;
  localparam int SUSP_ENTRY_MS   = 3;
  localparam int SUSP_EXIT_MS    = 2;
  // Strict upper bounds: minus one for the state hop after the timer, minus one to stay under
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * CLK_MHZ - 2;
  localparam int SLEEP_EXIT_CYC  = SLEEP_EXIT_US * CLK_MHZ - 2;
  localparam int SUSP_ENTRY_CYC  = SUSP_ENTRY_MS * 1000 * CLK_MHZ;
  localparam int SUSP_EXIT_CYC   = SUSP_EXIT_MS * 1000 * CLK_MHZ;

  // ****************************************************************
  // USB device state
  // ****************************************************************
  localparam int             ADDR_W           = 7;
  localparam int             CFG_W            = 8;
  localparam logic [6:0]     DEV_ADDR_DEFAULT = 7'h00;
  localparam logic [7:0]     CFG_UNCONFIGURED = 8'h00;

  typedef enum logic [1:0] {
    LINK_FULLY_ON = 2'h0,
    LINK_SLEEP    = 2'h1,
    LINK_SUSPEND  = 2'h2
  } hrl_link_e;

  // Gray codes along ON -> sleep -> ON and through suspend entry, suspend and exit; 3'h4 unused
  typedef enum logic [2:0] {
    HRL_LK_ON        = 3'h0,
    HRL_LK_SLP_ENT   = 3'h1,
    HRL_LK_SLEEP     = 3'h3,
    HRL_LK_SLP_EXIT  = 3'h2,
    HRL_LK_SUSP_ENT  = 3'h6,
    HRL_LK_SUSPEND   = 3'h7,
    HRL_LK_SUSP_EXIT = 3'h5
  } hrl_lk_e;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic             set_addr;
    logic [6:0]       addr;
    logic             set_cfg;
    logic [7:0]       cfg;
  } hrl_usb_req_s;

  typedef struct packed {
    logic sleep;
    logic suspend;
    logic resume;
  } hrl_lpm_req_s;

  typedef struct packed {
    hrl_lk_e          lk;
    hrl_link_e        link_state;
    logic             link_busy;
    logic [6:0]       dev_addr;
    logic [7:0]       cfg;
    logic             configured;
    logic [15:0]      por_cnt;
    logic             ext_s1;
    logic             ext_s2;
    logic             int_reset;
    logic             standby;
    logic             phy_en;
    logic             phy_oe_n;
    logic             txn_abort;
    logic             osc_en;
    logic             pll_en;
    logic             dn_reset;
  } hrl_state_s;

endpackage : hrl_pkg

/* File: rtl/hrl_lat_timer.sv */
// Latency timer: loads a cycle count and pulses done when it runs out
module hrl_lat_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic             i_sys_clk, // System clock
  input  wire logic             i_rst,     // Synchronous reset, active high
  input  wire logic             i_clear,   // Abandon any running count
  input  wire logic             i_start,   // Load and start
  input  wire logic [CNT_W-1:0] i_load,    // Cycles until done, at least 1
  output logic                  o_busy,    // Count running
  output logic                  o_done     // One-cycle pulse at expiry
);
  import hrl_pkg::*;

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [CNT_W-1:0] cnt;
  } hrl_tmr_s;

  hrl_tmr_s tmr_q;
  hrl_tmr_s tmr_d;

  always_comb begin
    tmr_d      = tmr_q;
    tmr_d.done = 1'b0;
    if (i_clear) begin
      tmr_d.busy = 1'b0;
      tmr_d.cnt  = '0;
    end else if (i_start) begin
      tmr_d.busy = 1'b1;
      tmr_d.cnt  = i_load;
    end else if (tmr_q.busy) begin
      if (tmr_q.cnt <= CNT_W'(1)) begin
        tmr_d.busy = 1'b0;
        tmr_d.done = 1'b1;
        tmr_d.cnt  = '0;
      end else begin
        tmr_d.cnt = tmr_q.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_d;
    end
  end

  assign o_busy = tmr_q.busy;
  assign o_done = tmr_q.done;

endmodule : hrl_lat_timer

/* File: rtl/hrl_rst_lpm.sv */
// Hub reset combiner, USB device state clearing and link power state tracking
// Contract
// - Three reset sources are honoured: power-on, the active-low chip reset pin and upstream bus reset.
// - After power is applied a timer holds the internal reset for a fixed time before release.
// - While the chip reset pin is low the device sits in low-current standby.
// - Chip reset disables the PHY and floats all differential pairs.
// - Chip reset aborts every transaction at once and keeps none of its state.
// - Chip reset returns every internal register to its default value.
// - Chip reset stops the crystal oscillator and the PLL while it is held.
// - Upstream bus reset sets the USB device address to zero.
// - Upstream bus reset returns the device to the unconfigured state.
// - Upstream bus reset moves a suspended device back to the active state.
// - Upstream bus reset is never forwarded to any downstream port.
// - Only the fully on, sleep and suspend link states exist.
// - Sleep entry completes in under 10 us and sleep exit in under 50 us.
// - Suspend entry takes about 3 ms and resume to fully on about 2 ms.
module hrl_rst_lpm
  import hrl_pkg::*;
#(
  parameter int POR_HOLD_CYCLES   = POR_HOLD_CYC,
  parameter int SUSP_ENTRY_CYCLES = SUSP_ENTRY_CYC,
  parameter int SUSP_EXIT_CYCLES  = SUSP_EXIT_CYC
) (
  input  wire logic                 i_sys_clk,       // 10 MHz system clock
  input  wire logic                 i_rst,           // Power-on, synchronous, active high
  input  wire logic                 i_chip_reset_n,  // External chip reset pin, active low
  input  wire logic                 i_bus_reset,     // Upstream bus reset seen, level
  input  wire hrl_pkg::hrl_usb_req_s i_usb_req,      // Address / configuration from enumeration
  input  wire hrl_pkg::hrl_lpm_req_s i_lpm_req,      // Sleep, suspend and resume requests
  input  wire logic                 i_dn_reset_req,  // Hub's own downstream port reset
  output logic                      o_int_reset,     // Internal reset to the rest of the chip
  output logic                      o_standby,       // Low-current standby
  output logic                      o_phy_en,        // PHY enable
  output logic                      o_phy_oe_n,      // Pair drive enable, low drives
  output logic                      o_txn_abort,     // Abort all transactions
  output logic                      o_osc_en,        // Crystal oscillator enable
  output logic                      o_pll_en,        // PLL enable
  output logic [6:0]                o_dev_addr,      // USB device address
  output logic [7:0]                o_cfg_value,     // Active configuration value
  output logic                      o_configured,    // Configured flag
  output hrl_pkg::hrl_link_e        o_link_state,    // Current link power state
  output logic                      o_link_busy,     // Link state change in progress
  output logic                      o_dn_port_reset  // Reset to downstream ports
);
  import hrl_pkg::*;

  // ****************************************************************
  // State and reset value
  // ****************************************************************
  localparam hrl_state_s ST_RST = '{
    lk:         HRL_LK_ON,
    link_state: LINK_FULLY_ON,
    link_busy:  1'b0,
    dev_addr:   DEV_ADDR_DEFAULT,
    cfg:        CFG_UNCONFIGURED,
    configured: 1'b0,
    por_cnt:    16'(POR_HOLD_CYCLES),
    ext_s1:     1'b1,
    ext_s2:     1'b1,
    int_reset:  1'b1,
    standby:    1'b0,
    phy_en:     1'b0,
    phy_oe_n:   1'b1,
    txn_abort:  1'b1,
    osc_en:     1'b1,
    pll_en:     1'b1,
    dn_reset:   1'b0
  };

  hrl_state_s       st_q;
  hrl_state_s       st_d;
  logic             int_rst;
  logic             tmr_clear;
  logic             tmr_start;
  logic [CNT_W-1:0] tmr_load;
  logic             tmr_busy;
  logic             tmr_done;

  function automatic hrl_link_e hrl_link_of(input hrl_lk_e lk);
    unique case (lk)
      HRL_LK_SLEEP, HRL_LK_SLP_EXIT:   hrl_link_of = LINK_SLEEP;
      HRL_LK_SUSPEND, HRL_LK_SUSP_EXIT: hrl_link_of = LINK_SUSPEND;
      default:                         hrl_link_of = LINK_FULLY_ON;
    endcase
  endfunction : hrl_link_of

  function automatic logic hrl_lk_moving(input hrl_lk_e lk);
    hrl_lk_moving = (lk == HRL_LK_SLP_ENT) || (lk == HRL_LK_SLP_EXIT) ||
                    (lk == HRL_LK_SUSP_ENT) || (lk == HRL_LK_SUSP_EXIT);
  endfunction : hrl_lk_moving

  // ****************************************************************
  // Next state
  // ****************************************************************
  assign int_rst   = (st_q.por_cnt != 16'h0000) || !st_q.ext_s2;
  assign tmr_clear = int_rst || i_bus_reset;

  always_comb begin
    st_d      = st_q;
    tmr_start = 1'b0;
    tmr_load  = '0;
    // Second flop alone reads the first
    st_d.ext_s1 = i_chip_reset_n;
    st_d.ext_s2 = st_q.ext_s1;
    if (st_q.por_cnt != 16'h0000) begin
      st_d.por_cnt = st_q.por_cnt - 16'h0001;
    end
    st_d.int_reset = int_rst;
    st_d.standby   = !st_q.ext_s2;
    st_d.phy_en    = !int_rst;
    st_d.phy_oe_n  = int_rst;
    st_d.txn_abort = int_rst;
    // Clocks can only be gated off, not slowed; power-on keeps them running for the timer
    st_d.osc_en    = st_q.ext_s2;
    st_d.pll_en    = st_q.ext_s2;
    // Bus reset deliberately absent here: it stays upstream
    st_d.dn_reset  = i_dn_reset_req && !int_rst;

    if (int_rst) begin
      st_d.dev_addr = DEV_ADDR_DEFAULT;
      st_d.cfg      = CFG_UNCONFIGURED;
      st_d.lk       = HRL_LK_ON;
    end else if (i_bus_reset) begin
      st_d.dev_addr = DEV_ADDR_DEFAULT;
      st_d.cfg      = CFG_UNCONFIGURED;
      st_d.lk       = HRL_LK_ON;
    end else begin
      if (i_usb_req.set_addr) begin
        st_d.dev_addr = i_usb_req.addr;
      end
      if (i_usb_req.set_cfg) begin
        st_d.cfg = i_usb_req.cfg;
      end
      unique case (st_q.lk)
        HRL_LK_ON: begin
          if (i_lpm_req.sleep) begin
            st_d.lk   = HRL_LK_SLP_ENT;
            tmr_start = 1'b1;
            tmr_load  = CNT_W'(SLEEP_ENTRY_CYC);
          end else if (i_lpm_req.suspend) begin
            st_d.lk   = HRL_LK_SUSP_ENT;
            tmr_start = 1'b1;
            tmr_load  = CNT_W'(SUSP_ENTRY_CYCLES);
          end
        end
        HRL_LK_SLP_ENT: begin
          if (tmr_done) begin
            st_d.lk = HRL_LK_SLEEP;
          end
        end
        HRL_LK_SLEEP: begin
          if (i_lpm_req.resume) begin
            st_d.lk   = HRL_LK_SLP_EXIT;
            tmr_start = 1'b1;
            tmr_load  = CNT_W'(SLEEP_EXIT_CYC);
          end
        end
        HRL_LK_SLP_EXIT: begin
          if (tmr_done) begin
            st_d.lk = HRL_LK_ON;
          end
        end
        HRL_LK_SUSP_ENT: begin
          // Resume during entry is ignored; only a resume once suspended starts the exit
          if (tmr_done) begin
            st_d.lk = HRL_LK_SUSPEND;
          end
        end
        HRL_LK_SUSPEND: begin
          if (i_lpm_req.resume) begin
            st_d.lk   = HRL_LK_SUSP_EXIT;
            tmr_start = 1'b1;
            tmr_load  = CNT_W'(SUSP_EXIT_CYCLES);
          end
        end
        HRL_LK_SUSP_EXIT: begin
          if (tmr_done) begin
            st_d.lk = HRL_LK_ON;
          end
        end
        default: begin
          st_d.lk = HRL_LK_ON;
        end
      endcase
    end
    st_d.configured = (st_d.cfg != CFG_UNCONFIGURED);
    st_d.link_state = hrl_link_of(st_d.lk);
    st_d.link_busy  = hrl_lk_moving(st_d.lk);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  hrl_lat_timer #(
    .CNT_W (CNT_W)
  ) u_lat_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clear   (tmr_clear),
    .i_start   (tmr_start),
    .i_load    (tmr_load),
    .o_busy    (tmr_busy),
    .o_done    (tmr_done)
  );

  assign o_int_reset     = st_q.int_reset;
  assign o_standby       = st_q.standby;
  assign o_phy_en        = st_q.phy_en;
  assign o_phy_oe_n      = st_q.phy_oe_n;
  assign o_txn_abort     = st_q.txn_abort;
  assign o_osc_en        = st_q.osc_en;
  assign o_pll_en        = st_q.pll_en;
  assign o_dev_addr      = st_q.dev_addr;
  assign o_cfg_value     = st_q.cfg;
  assign o_configured    = st_q.configured;
  assign o_link_state    = st_q.link_state;
  assign o_link_busy     = st_q.link_busy;
  assign o_dn_port_reset = st_q.dn_reset;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  localparam int A_SLP_ENT  = SLEEP_ENTRY_CYC + 1;
  localparam int A_SLP_EXIT = SLEEP_EXIT_CYC + 1;
  localparam int A_SUSP_MAX = SUSP_ENTRY_CYCLES + 1;
  localparam int A_RES_MAX  = SUSP_EXIT_CYCLES + 1;

  logic [15:0] a_susp_cnt;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || st_q.lk != HRL_LK_SUSP_ENT) begin
      a_susp_cnt <= 16'h0000;
    end else begin
      a_susp_cnt <= a_susp_cnt + 16'h0001;
    end
  end

  // Resume counter mirrors the entry one; a bus reset may cut either interval short
  logic [15:0] a_resume_cnt;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || st_q.lk != HRL_LK_SUSP_EXIT) begin
      a_resume_cnt <= 16'h0000;
    end else begin
      a_resume_cnt <= a_resume_cnt + 16'h0001;
    end
  end

  default clocking a_cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_por_hold: assert property ($fell(i_rst) |-> o_int_reset [*8])
    else $error("internal reset released too early after power-on");
  a_int_rst_or: assert property (
      (st_q.por_cnt != 16'h0000 || !st_q.ext_s2) |=> o_int_reset)
    else $error("internal reset not asserted for its sources");
  a_standby_pin: assert property (!st_q.ext_s2 |=> o_standby && o_txn_abort)
    else $error("standby or abort missing during chip reset");
  a_phy_float: assert property (!st_q.ext_s2 |=> !o_phy_en && o_phy_oe_n)
    else $error("PHY still driving during chip reset");
  a_txn_abort: assert property ($fell(st_q.ext_s2) |=> o_txn_abort && !o_link_busy)
    else $error("transaction not aborted on chip reset");
  a_regs_default: assert property (!st_q.ext_s2 |=> o_dev_addr == 7'h00 && !o_configured)
    else $error("registers not at default during chip reset");
  a_clk_halt: assert property (!st_q.ext_s2 |=> !o_osc_en && !o_pll_en)
    else $error("oscillator or PLL running during chip reset");
  a_bus_addr: assert property (i_bus_reset |=> o_dev_addr == 7'h00)
    else $error("address not cleared by bus reset");
  a_bus_cfg: assert property (i_bus_reset |=> !o_configured && o_cfg_value == 8'h00)
    else $error("configuration not cleared by bus reset");
  a_bus_wake: assert property (
      i_bus_reset |=> o_link_state == LINK_FULLY_ON && !o_link_busy)
    else $error("bus reset did not return link to fully on");
  a_no_fwd: assert property (i_bus_reset && !i_dn_reset_req |=> !o_dn_port_reset)
    else $error("bus reset forwarded downstream");
  a_legal_link: assert property (
      o_link_state inside {LINK_FULLY_ON, LINK_SLEEP, LINK_SUSPEND})
    else $error("illegal link power state");
  a_sleep_entry: assert property (
      st_q.lk == HRL_LK_SLP_ENT |-> ##[1:A_SLP_ENT] st_q.lk != HRL_LK_SLP_ENT)
    else $error("sleep entry too slow");
  a_sleep_exit: assert property (
      st_q.lk == HRL_LK_SLP_EXIT |-> ##[1:A_SLP_EXIT] st_q.lk != HRL_LK_SLP_EXIT)
    else $error("sleep exit too slow");
  a_susp_entry: assert property (a_susp_cnt <= 16'(A_SUSP_MAX))
    else $error("suspend entry overran its time");
  a_susp_exit: assert property (a_resume_cnt <= 16'(A_RES_MAX))
    else $error("suspend exit overran its time");
  a_susp_exact: assert property (
      $fell(st_q.lk == HRL_LK_SUSP_ENT) && st_q.lk == HRL_LK_SUSPEND
      |-> a_susp_cnt == 16'(A_SUSP_MAX))
    else $error("suspend entry time off");
  a_resume_exact: assert property (
      $fell(st_q.lk == HRL_LK_SUSP_EXIT) && st_q.lk == HRL_LK_ON && !$past(tmr_clear)
      |-> a_resume_cnt == 16'(A_RES_MAX))
    else $error("suspend exit time off");
  a_timer_idle: assert property (!o_link_busy |-> !tmr_busy)
    else $error("latency timer running outside a link change");
  a_bus_local: assert property (i_bus_reset && !int_rst
      |=> !o_int_reset && o_phy_en && o_osc_en && o_pll_en)
    else $error("bus reset disturbed chip-level controls");

  c_sleep_in: cover property (st_q.lk == HRL_LK_SLP_ENT ##1 st_q.lk == HRL_LK_SLEEP);
  c_sleep_trip: cover property (st_q.lk == HRL_LK_SLP_EXIT ##1 st_q.lk == HRL_LK_ON);
  c_suspend_in: cover property (st_q.lk == HRL_LK_SUSP_ENT ##1 st_q.lk == HRL_LK_SUSPEND);
  c_bus_in_susp: cover property (st_q.lk == HRL_LK_SUSPEND && i_bus_reset);
  c_chip_reset: cover property ($fell(st_q.ext_s2));

endmodule : hrl_rst_lpm

/* File: sim/hrl_host_model.sv */
// Upstream host model: bus reset signalling and enumeration strobes
module hrl_host_model
  import hrl_pkg::*;
(
  input  wire logic              i_sys_clk,   // System clock
  output logic                   o_bus_reset, // Bus reset toward the hub
  output hrl_pkg::hrl_usb_req_s  o_usb_req    // Address and configuration strobes
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_bus_reset = 1'b0;
    o_usb_req   = '0;
  end

  // Holds reset for n edges, all changes made at the falling edge
  task automatic bus_reset(input int n);
    @(negedge i_sys_clk);
    o_bus_reset = 1'b1;
    repeat (n) @(negedge i_sys_clk);
    o_bus_reset = 1'b0;
  endtask : bus_reset

  // Released fields show inverted data so stale values cannot pass for fresh ones
  task automatic enumerate(input logic [6:0] a, input logic [7:0] c);
    @(negedge i_sys_clk);
    o_usb_req.set_addr = 1'b1;
    o_usb_req.addr     = a;
    @(negedge i_sys_clk);
    o_usb_req.set_addr = 1'b0;
    o_usb_req.addr     = ~a;
    o_usb_req.set_cfg  = 1'b1;
    o_usb_req.cfg      = c;
    @(negedge i_sys_clk);
    o_usb_req.set_cfg  = 1'b0;
    o_usb_req.cfg      = ~c;
  endtask : enumerate
endmodule : hrl_host_model

/* File: sim/tb.sv */
// Testbench for the hub reset combiner and link power tracker
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import hrl_pkg::*;

  // ****************************************************************
  // Setup
  // ****************************************************************
  // Short counts keep suspend runs brief
  localparam int PH = 8;
  localparam int SE = 40;
  localparam int SX = 30;
  typedef struct packed {hrl_link_e st; logic [15:0] lat;} hrl_note_s;

  logic         sys_clk      = 1'b0;
  logic         rst          = 1'b1;
  logic         chip_reset_n = 1'b1;
  logic         dn_req       = 1'b0;
  hrl_lpm_req_s lpm          = '0;
  logic         bus_reset;
  hrl_usb_req_s usb_req;
  logic         int_reset, standby, phy_en, phy_oe_n, txn_abort, osc_en, pll_en;
  logic         configured, link_busy, dn_port_reset;
  logic [6:0]   dev_addr;
  logic [7:0]   cfg_value;
  hrl_link_e    link_state;
  logic [6:0]   ctl;
  int           err_count = 0;
  int           check_count = 0;
  int           cyc = 0;
  int           rise_cyc = 0;
  hrl_note_s    notes[$];
  hrl_note_s    note;
  hrl_link_e    st_prev = LINK_FULLY_ON;
  logic         busy_prev = 1'b0;
  logic [31:0]  seed = 32'h000068A6;

  assign ctl = {int_reset, txn_abort, phy_en, phy_oe_n, osc_en, pll_en, standby};

  always #50 sys_clk = ~sys_clk;

  hrl_rst_lpm #(.POR_HOLD_CYCLES(PH), .SUSP_ENTRY_CYCLES(SE), .SUSP_EXIT_CYCLES(SX))
  i_hrl_rst_lpm (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_chip_reset_n(chip_reset_n),
    .i_bus_reset(bus_reset), .i_usb_req(usb_req), .i_lpm_req(lpm),
    .i_dn_reset_req(dn_req), .o_int_reset(int_reset), .o_standby(standby),
    .o_phy_en(phy_en), .o_phy_oe_n(phy_oe_n), .o_txn_abort(txn_abort),
    .o_osc_en(osc_en), .o_pll_en(pll_en), .o_dev_addr(dev_addr),
    .o_cfg_value(cfg_value), .o_configured(configured), .o_link_state(link_state),
    .o_link_busy(link_busy), .o_dn_port_reset(dn_port_reset));

  hrl_host_model i_hrl_host_model (
    .i_sys_clk(sys_clk), .o_bus_reset(bus_reset), .o_usb_req(usb_req));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // Strobe for one cycle; the expected link change is noted first
  task automatic lpm_req(input logic [2:0] v, input logic push, input hrl_link_e st,
                         input logic [15:0] lat);
    @(negedge sys_clk);
    if (push) begin
      notes.push_back(hrl_note_s'{st, lat});
    end
    lpm = hrl_lpm_req_s'(v);
    @(negedge sys_clk);
    lpm = '0;
  endtask : lpm_req

  task automatic wait_link(input hrl_link_e st);
    int n;
    n = 0;
    while (!(link_state === st && link_busy === 1'b0) && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_link

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // Every link change must match the oldest note, latency counted from busy rise
  always @(negedge sys_clk) begin
    if (!rst) begin
      if (link_busy === 1'b1 && busy_prev !== 1'b1) begin
        rise_cyc = cyc;
      end
      if (link_state !== st_prev) begin
        if (notes.size() == 0) begin
          check(16'(link_state), 16'(st_prev));
        end else begin
          note = notes.pop_front();
          check(16'(link_state), 16'(note.st));
          if (note.lat !== 16'hFFFF) check(16'(cyc - rise_cyc), note.lat);
        end
      end
    end
    st_prev   = link_state;
    busy_prev = link_busy;
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [31:0] r;
    logic [6:0]  a;
    logic [7:0]  c;
    int          n;
    repeat (19) @(negedge sys_clk);
    check(16'(ctl), 16'h006E);
    check(16'({dev_addr, link_state}), 16'h0000);
    @(negedge sys_clk);
    rst = 1'b0;
    n = 0;
    while (int_reset !== 1'b0 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    check(16'(n), 16'(PH + 1));
    check(16'(ctl), 16'h0016);
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      a = r[6:0];
      c = (i == 0) ? 8'h00 : r[14:7];
      i_hrl_host_model.enumerate(a, c);
      check(16'({dev_addr, cfg_value}), 16'({a, c}));
      check(16'(configured), 16'(c != 8'h00));
    end
    dn_req = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(16'(dn_port_reset), 16'h0001);
    dn_req = 1'b0;
    i_hrl_host_model.bus_reset(3);
    check(16'({dev_addr, cfg_value}), 16'h0000);
    check(16'({configured, dn_port_reset}), 16'h0000);
    check(16'(ctl), 16'h0016);
    i_hrl_host_model.enumerate(a, 8'h01);
    // Latency counts the timer plus the state hop that follows it
    lpm_req(3'h6, 1'b1, LINK_SLEEP, 16'(SLEEP_ENTRY_CYC + 1));
    check(16'(link_busy), 16'h0001);
    wait_link(LINK_SLEEP);
    // Suspend asked from sleep must be ignored
    lpm_req(3'h2, 1'b0, LINK_SUSPEND, 16'h0000);
    lpm_req(3'h1, 1'b1, LINK_FULLY_ON, 16'(SLEEP_EXIT_CYC + 1));
    wait_link(LINK_FULLY_ON);
    lpm_req(3'h2, 1'b1, LINK_SUSPEND, 16'(SE + 1));
    lpm_req(3'h1, 1'b0, LINK_FULLY_ON, 16'h0000);
    wait_link(LINK_SUSPEND);
    lpm_req(3'h1, 1'b1, LINK_FULLY_ON, 16'(SX + 1));
    wait_link(LINK_FULLY_ON);
    lpm_req(3'h2, 1'b1, LINK_SUSPEND, 16'(SE + 1));
    wait_link(LINK_SUSPEND);
    notes.push_back(hrl_note_s'{LINK_FULLY_ON, 16'hFFFF});
    i_hrl_host_model.bus_reset(1);
    repeat (2) @(negedge sys_clk);
    check(16'({link_state, link_busy}), 16'({LINK_FULLY_ON, 1'b0}));
    i_hrl_host_model.enumerate(a, 8'h05);
    chip_reset_n = 1'b0;
    dn_req       = 1'b1;
    repeat (4) @(negedge sys_clk);
    check(16'(ctl), 16'h0069);
    check(16'({dev_addr, cfg_value, dn_port_reset}), 16'h0000);
    chip_reset_n = 1'b1;
    dn_req       = 1'b0;
    repeat (4) @(negedge sys_clk);
    check(16'(ctl), 16'h0016);
    check(16'(notes.size()), 16'h0000);
    tally_and_finish();
  end
endmodule : tb
